// *** core/cffc_pkg.sv ***
// Purpose: shared constants of the CAN filter and FIFO control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: byte offsets, field positions and reset values
package cffc_pkg;
   // register byte offsets
   localparam logic [7:0] MAIN_OFS = 8'h00;
   localparam logic [7:0] FLT0_OFS = 8'h04;
   localparam logic [7:0] FLT1_OFS = 8'h08;
   localparam logic [7:0] MASK_BASE = 8'h10;
   localparam logic [7:0] FVAL_BASE = 8'h20;
   localparam logic [7:0] ISTAT_OFS = 8'h30;
   localparam logic [7:0] IMASK_OFS = 8'h34;
   localparam logic [7:0] FIFO_BASE = 8'h80;
   // filter byte layout
   localparam int FLT_EN_BIT = 7;
   localparam int FLT_MSEL_LSB = 5;
   localparam int FLT_DEST_LSB = 0;
   // fifo control byte layout; FIFO reset is bit 14, in the next byte
   localparam int FIFO_DIR_BIT = 7;
   localparam int FIFO_ABT_BIT = 6;
   localparam int FIFO_ARB_BIT = 5;
   localparam int FIFO_ERR_BIT = 4;
   localparam int FIFO_REQ_BIT = 3;
   localparam int FIFO_RTR_BIT = 2;
   localparam int FIFO_PRIO_LSB = 0;
   localparam int FIFO_RST_BIT = 14;
   // main control
   localparam int MODE_LSB = 21;
   localparam logic [2:0] MODE_CONFIG = 3'h4;
   localparam logic [2:0] MODE_RESET = MODE_CONFIG;
   // interrupt status bits, their count, and the filter count
   localparam int EV_DONE = 0;
   localparam int EV_ABORT = 1;
   localparam int EV_ARB = 2;
   localparam int EV_ERR = 3;
   localparam int EV_RXACC = 4;
   localparam int EV_RXRTR = 5;
   localparam int NEV = 6;
   localparam int NFLT = 4;
endpackage : cffc_pkg

// *** core/cffc_fifo_slot.sv ***
// Purpose: control and status byte of one CAN FIFO
// Assumes: event inputs are one-cycle pulses on core_clk
// Notes: read-clear inputs carry only bits software actually saw
`timescale 1ns/1ps
`default_nettype none
module cffc_fifo_slot (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // software side
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   input wire logic fifoRst,
   input wire logic cfgMode,
   input wire logic clrArb,
   input wire logic clrErr,
   // engine side
   input wire logic evDone,
   input wire logic evAbort,
   input wire logic evArb,
   input wire logic evErr,
   input wire logic queueEmpty,
   input wire logic remoteHit,
   // state out
   output logic [7:0] ctrl,
   output logic reqPend,
   output logic abortPend
);
   logic dirTx_reg, aborted_reg, arbLost_reg, busErr_reg, sendReq_reg, autoRtr_reg;
   logic [1:0] prio_reg;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dirTx_reg <= 1'b0;
      end else if (wrEn && cfgMode) begin
         dirTx_reg <= wrData[cffc_pkg::FIFO_DIR_BIT];
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prio_reg <= 2'h0;
         autoRtr_reg <= 1'b0;
      end else if (wrEn) begin
         prio_reg <= wrData[cffc_pkg::FIFO_PRIO_LSB +: 2];
         autoRtr_reg <= wrData[cffc_pkg::FIFO_RTR_BIT];
      end
   end

   // hardware set and clear outrank the software write
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sendReq_reg <= 1'b0;
      end else if (evDone && queueEmpty) begin
         sendReq_reg <= 1'b0;
      end else if (remoteHit && autoRtr_reg) begin
         sendReq_reg <= 1'b1;
      end else if (fifoRst) begin
         sendReq_reg <= 1'b0;
      end else if (wrEn && dirTx_reg) begin
         sendReq_reg <= wrData[cffc_pkg::FIFO_REQ_BIT];
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         abortPend <= 1'b0;
      end else if (fifoRst || evAbort || evDone) begin
         abortPend <= 1'b0;
      end else if (wrEn && dirTx_reg && sendReq_reg && !wrData[cffc_pkg::FIFO_REQ_BIT]) begin
         abortPend <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         aborted_reg <= 1'b0;
      end else if (evAbort) begin
         aborted_reg <= 1'b1;
      end else if (evDone || fifoRst) begin
         aborted_reg <= 1'b0;
      end
   end

   // set wins over a read or reset clear
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         arbLost_reg <= 1'b0;
         busErr_reg <= 1'b0;
      end else begin
         arbLost_reg <= evArb || (arbLost_reg && !clrArb && !fifoRst);
         busErr_reg <= evErr || (busErr_reg && !clrErr && !fifoRst);
      end
   end

   assign ctrl = {dirTx_reg, aborted_reg, arbLost_reg, busErr_reg, sendReq_reg, autoRtr_reg, prio_reg};
   assign reqPend = sendReq_reg && dirTx_reg;
endmodule : cffc_fifo_slot
`default_nettype wire

// *** core/cffc_top.sv ***
// Purpose: CAN acceptance filter and transmit FIFO control, APB slave
// Assumes: engine and APB signals share core_clk; no synchronisers needed
// Notes: filters 0,1,2,3 live in two control words
// Operation
// - each filter has an enable bit; 1 active, 0 disabled
// - two-bit mask choice picks acceptance mask 0 to 3
// - five-bit destination names the FIFO 0 to 31 receiving matches
// - word 0 holds filter 0 in bits 7-0, filter 1 in 15-8
// - word 1 holds filter 2 in bits 7-0, filter 3 in 15-8
// - mask choice and destination writable only while the filter is disabled
// - aborted flag is 1 after abort, 0 after completion or FIFO reset
// - arbitration-lost flag sets when a sent message loses arbitration
// - bus-error flag sets when a bus error hits a sent message
// - arbitration-lost and bus-error flags clear on read and FIFO reset
// - send request clears itself once the FIFO's queue is all sent
// - clearing a set send request asks for an abort
// - send request writes have no effect on a receive FIFO
// - with auto-remote on, a received remote request sets send request
// - two-bit priority, 11 highest down to 00 lowest
// - FIFO direction bit writable only in configuration mode 100
`timescale 1ns/1ps
`default_nettype none
module cffc_top #(
   parameter int NFIFO = 32,
   parameter int ID_W = 11
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq,
   // transmit engine
   output logic txOffer,
   output logic [4:0] txOfferFifo,
   output logic [NFIFO-1:0] abortReq,
   input wire logic txDone,
   input wire logic txAborted,
   input wire logic txArbLost,
   input wire logic txBusErr,
   input wire logic [4:0] txEvFifo,
   input wire logic [NFIFO-1:0] txQueueEmpty,
   // receive engine
   input wire logic rxValid,
   input wire logic [ID_W-1:0] rxId,
   input wire logic rxRemote,
   output logic rxStore,
   output logic [4:0] rxStoreFifo
);
   logic [7:0] fltCfg_reg [cffc_pkg::NFLT];
   logic [ID_W-1:0] mask_reg [4];
   logic [ID_W-1:0] fval_reg [cffc_pkg::NFLT];
   logic [2:0] mode_reg;
   logic [cffc_pkg::NEV-1:0] istat_reg, imask_reg, evVec, clrIstat;
   logic [31:0] rdMux, prdata_reg;
   logic hit, acc, wrOk, rdAcc, cfgMode;
   logic [4:0] fifoIdx;
   logic [7:0] slotCtrl [NFIFO];
   logic [NFIFO-1:0] reqPend, remoteHit;
   logic [3:0] matchVec;
   logic [1:0] pick;
   logic [4:0] bestIdx;
   logic [1:0] bestPrio, offerPrio_reg, maxPrio;
   logic anyReq, rxRemote_reg;

   ////////////////////////////////////////////////////////////////////////
   // apb decode: zero wait states, read data captured in setup
   assign acc = psel && penable;
   assign wrOk = acc && pwrite && hit;
   assign rdAcc = acc && !pwrite && hit;
   assign pready = 1'b1;
   assign pslverr = acc && !hit;
   assign prdata = prdata_reg;
   assign fifoIdx = paddr[6:2];
   assign cfgMode = (mode_reg == cffc_pkg::MODE_CONFIG);

   always_comb begin
      rdMux = '0;
      hit = (paddr[1:0] == 2'h0);
      if (paddr[7]) begin
         hit = hit && (32'(fifoIdx) < NFIFO);
         if (hit) begin
            rdMux = {24'h0, slotCtrl[fifoIdx]};
         end
      end else if (paddr[7:4] == cffc_pkg::MASK_BASE[7:4]) begin
         rdMux = 32'(mask_reg[paddr[3:2]]);
      end else if (paddr[7:4] == cffc_pkg::FVAL_BASE[7:4]) begin
         rdMux = 32'(fval_reg[paddr[3:2]]);
      end else if (paddr == cffc_pkg::MAIN_OFS) begin
         rdMux[cffc_pkg::MODE_LSB +: 3] = mode_reg;
      end else if (paddr == cffc_pkg::FLT0_OFS) begin
         rdMux = {16'h0, fltCfg_reg[1], fltCfg_reg[0]};
      end else if (paddr == cffc_pkg::FLT1_OFS) begin
         rdMux = {16'h0, fltCfg_reg[3], fltCfg_reg[2]};
      end else if (paddr == cffc_pkg::ISTAT_OFS) begin
         rdMux = 32'(istat_reg);
      end else if (paddr == cffc_pkg::IMASK_OFS) begin
         rdMux = 32'(imask_reg);
      end else begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prdata_reg <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= rdMux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mode_reg <= cffc_pkg::MODE_RESET;
      end else if (wrOk && paddr == cffc_pkg::MAIN_OFS && pstrb[2]) begin
         mode_reg <= pwdata[cffc_pkg::MODE_LSB +: 3];
      end
   end

   // enable is always writable; fields only while disabled
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int k = 0; k < cffc_pkg::NFLT; k++) begin
            fltCfg_reg[k] <= 8'h0;
         end
      end else begin
         for (int k = 0; k < cffc_pkg::NFLT; k++) begin
            if (wrOk && pstrb[k % 2] && paddr == (k < 2 ? cffc_pkg::FLT0_OFS : cffc_pkg::FLT1_OFS)) begin
               fltCfg_reg[k][cffc_pkg::FLT_EN_BIT] <= pwdata[8 * (k % 2) + 7];
               if (!fltCfg_reg[k][cffc_pkg::FLT_EN_BIT]) begin
                  fltCfg_reg[k][6:0] <= pwdata[8 * (k % 2) +: 7];
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int k = 0; k < 4; k++) begin
            mask_reg[k] <= '0;
            fval_reg[k] <= '0;
         end
      end else if (wrOk && paddr[7:4] == cffc_pkg::MASK_BASE[7:4]) begin
         mask_reg[paddr[3:2]] <= pwdata[ID_W-1:0];
      end else if (wrOk && paddr[7:4] == cffc_pkg::FVAL_BASE[7:4]) begin
         fval_reg[paddr[3:2]] <= pwdata[ID_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupts: clear only bits the read returned, so a late event survives
   assign evVec = {rxStore && rxRemote_reg, rxStore, txBusErr, txArbLost, txAborted, txDone};
   assign clrIstat = (rdAcc && paddr == cffc_pkg::ISTAT_OFS) ? prdata_reg[cffc_pkg::NEV-1:0] : '0;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         istat_reg <= '0;
         imask_reg <= '0;
         irq <= 1'b0;
      end else begin
         istat_reg <= (istat_reg & ~clrIstat) | evVec;
         irq <= |(istat_reg & imask_reg);
         if (wrOk && paddr == cffc_pkg::IMASK_OFS) begin
            imask_reg <= pwdata[cffc_pkg::NEV-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fifo control slots
   for (genvar n = 0; n < NFIFO; n++) begin : g_slot
      logic slotWr, slotRd, evHere;
      assign slotWr = wrOk && paddr[7] && fifoIdx == 5'(n);
      assign slotRd = rdAcc && paddr[7] && fifoIdx == 5'(n);
      assign evHere = (txEvFifo == 5'(n));
      cffc_fifo_slot u_slot (
         .core_clk(core_clk),
         .reset(reset),
         .wrEn(slotWr && pstrb[0]),
         .wrData(pwdata[7:0]),
         .fifoRst(slotWr && pstrb[1] && pwdata[cffc_pkg::FIFO_RST_BIT]),
         .cfgMode(cfgMode),
         .clrArb(slotRd && prdata_reg[cffc_pkg::FIFO_ARB_BIT]),
         .clrErr(slotRd && prdata_reg[cffc_pkg::FIFO_ERR_BIT]),
         .evDone(txDone && evHere),
         .evAbort(txAborted && evHere),
         .evArb(txArbLost && evHere),
         .evErr(txBusErr && evHere),
         .queueEmpty(txQueueEmpty[n]),
         .remoteHit(remoteHit[n]),
         .ctrl(slotCtrl[n]),
         .reqPend(reqPend[n]),
         .abortPend(abortReq[n])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit arbitration: ties go to the lowest fifo number
   always_comb begin
      bestIdx = 5'h0;
      bestPrio = 2'h0;
      anyReq = 1'b0;
      for (int n = 0; n < NFIFO; n++) begin
         if (reqPend[n] && (!anyReq || slotCtrl[n][1:0] > bestPrio)) begin
            anyReq = 1'b1;
            bestIdx = 5'(n);
            bestPrio = slotCtrl[n][1:0];
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         txOffer <= 1'b0;
         txOfferFifo <= 5'h0;
         offerPrio_reg <= 2'h0;
      end else begin
         txOffer <= anyReq;
         txOfferFifo <= bestIdx;
         offerPrio_reg <= bestPrio;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // acceptance filtering: lowest filter slot wins on several matches
   always_comb begin
      pick = 2'h0;
      for (int k = 0; k < cffc_pkg::NFLT; k++) begin
         matchVec[k] = fltCfg_reg[k][cffc_pkg::FLT_EN_BIT] &&
            (((rxId ^ fval_reg[k]) & mask_reg[fltCfg_reg[k][6:5]]) == '0);
      end
      for (int k = cffc_pkg::NFLT - 1; k >= 0; k--) begin
         if (matchVec[k]) begin
            pick = 2'(k);
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rxStore <= 1'b0;
         rxStoreFifo <= 5'h0;
         rxRemote_reg <= 1'b0;
      end else begin
         rxStore <= rxValid && (|matchVec);
         rxStoreFifo <= fltCfg_reg[pick][cffc_pkg::FLT_DEST_LSB +: 5];
         rxRemote_reg <= rxRemote;
      end
   end

   for (genvar n = 0; n < NFIFO; n++) begin : g_rtr
      assign remoteHit[n] = rxStore && rxRemote_reg && rxStoreFifo == 5'(n);
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   always_comb begin
      maxPrio = 2'h0;
      for (int n = 0; n < NFIFO; n++) begin
         if (reqPend[n] && slotCtrl[n][1:0] > maxPrio) begin
            maxPrio = slotCtrl[n][1:0];
         end
      end
   end

   // offered fifo must have been pending one cycle earlier; done can clear it at the offer edge
   logic [NFIFO-1:0] reqPendPast_reg;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reqPendPast_reg <= '0;
      end else begin
         reqPendPast_reg <= reqPend;
      end
   end

   property p_flt_lock;
      wrOk && paddr == cffc_pkg::FLT0_OFS && pstrb[0] && fltCfg_reg[0][7] |=> $stable(fltCfg_reg[0][6:0]);
   endproperty
   a_flt_lock: assert property (p_flt_lock) else $error("locked filter fields changed");

   property p_no_filter;
      rxValid && !fltCfg_reg[0][7] && !fltCfg_reg[1][7] && !fltCfg_reg[2][7] && !fltCfg_reg[3][7] |=> !rxStore;
   endproperty
   a_no_filter: assert property (p_no_filter) else $error("stored with all filters disabled");

   property p_store_dest;
      rxValid && matchVec[0] |=> rxStore && rxStoreFifo == $past(fltCfg_reg[0][4:0]);
   endproperty
   a_store_dest: assert property (p_store_dest) else $error("match not stored in destination");

   property p_offer_best;
      anyReq |=> txOffer && offerPrio_reg == $past(maxPrio) && reqPendPast_reg[txOfferFifo];
   endproperty
   a_offer_best: assert property (p_offer_best) else $error("offered fifo is not highest");

   property p_done_clear;
      txDone && txEvFifo == 5'h3 && txQueueEmpty[3] && !remoteHit[3] |=> !slotCtrl[3][3];
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("send request kept after queue sent");

   property p_done_keep;
      txDone && txEvFifo == 5'h3 && !txQueueEmpty[3] && slotCtrl[3][3] && !wrOk |=> slotCtrl[3][3];
   endproperty
   a_done_keep: assert property (p_done_keep) else $error("send request lost with queue not empty");

   property p_abort_req;
      wrOk && paddr == cffc_pkg::FIFO_BASE + 8'h0c && pstrb[0] && slotCtrl[3][7] && slotCtrl[3][3] && !pwdata[3]
         && !txDone && !txAborted && !(pstrb[1] && pwdata[14])
         |=> abortReq[3] ##1 abortReq[3] || $past(txAborted || txDone);
   endproperty
   a_abort_req: assert property (p_abort_req) else $error("clearing send request did not abort");

   property p_rx_fifo;
      wrOk && paddr == cffc_pkg::FIFO_BASE + 8'h18 && !slotCtrl[6][7] && !remoteHit[6] |=> !$rose(slotCtrl[6][3]);
   endproperty
   a_rx_fifo: assert property (p_rx_fifo) else $error("send request set on receive fifo");

   property p_dir_lock;
      wrOk && paddr == cffc_pkg::FIFO_BASE + 8'h1c && !cfgMode |=> $stable(slotCtrl[7][7]);
   endproperty
   a_dir_lock: assert property (p_dir_lock) else $error("direction changed outside config mode");

   property p_aborted;
      txAborted && txEvFifo == 5'h3 |=> slotCtrl[3][6] ##1 slotCtrl[3][6] || $past(txDone || wrOk);
   endproperty
   a_aborted: assert property (p_aborted) else $error("aborted flag not set");

   property p_arb_clear;
      rdAcc && paddr == cffc_pkg::FIFO_BASE + 8'h0c && prdata_reg[5] && !(txArbLost && txEvFifo == 5'h3)
         |=> !slotCtrl[3][5];
   endproperty
   a_arb_clear: assert property (p_arb_clear) else $error("arbitration flag survived read");

   property p_arb_set;
      txArbLost && txEvFifo == 5'h3 |=> slotCtrl[3][5];
   endproperty
   a_arb_set: assert property (p_arb_set) else $error("arbitration flag not set");

   property p_err_set;
      txBusErr && txEvFifo == 5'h3 |=> slotCtrl[3][4];
   endproperty
   a_err_set: assert property (p_err_set) else $error("bus error flag not set");

   c_store: cover property (rxValid ##1 rxStore);
   c_offer: cover property (anyReq ##1 txOffer ##[1:20] txDone);
   c_abort: cover property (abortReq[3] ##[1:20] txAborted);
endmodule : cffc_top
`default_nettype wire

// *** verification/cffc_can_node.sv ***
// Purpose: behavioural far-side node and transmit engine for the filter/FIFO block
// Assumes: one event pulse per cycle, qualified by txEvFifo
// Notes: lat and fault come from the bench per scenario
`timescale 1ns/1ps
`default_nettype none
module cffc_can_node (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // scenario control
   input wire logic [5:0] lat,
   input wire logic [1:0] fault,
   input wire logic [31:0] qBusy,
   // design side
   input wire logic txOffer,
   input wire logic [4:0] txOfferFifo,
   input wire logic [31:0] abortReq,
   output logic txDone,
   output logic txAborted,
   output logic txArbLost,
   output logic txBusErr,
   output logic [4:0] txEvFifo,
   output logic [31:0] txQueueEmpty
);
   logic [4:0] f;
   // a busy queue keeps more messages behind the one being sent
   assign txQueueEmpty = ~qBusy;
   ////////////////////////////////////////////////////////////////////////////
   task automatic pulse(input logic [3:0] v);
      txEvFifo <= f;
      {txDone, txAborted, txArbLost, txBusErr} <= v;
      @(posedge core_clk);
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {txDone, txAborted, txArbLost, txBusErr} = 4'h0;
      txEvFifo = 5'h00;
      f = 5'h00;
      forever begin
         @(posedge core_clk);
         if (!reset && abortReq != 32'h0) begin
            for (int i = 0; i < 32; i++) begin
               if (abortReq[i]) f = 5'(i);
            end
            pulse(4'h4);
            {txDone, txAborted, txArbLost, txBusErr} <= 4'h0;
         end else if (!reset && txOffer) begin
            // slow bus: offer may be withdrawn while we wait
            repeat (lat) @(posedge core_clk);
            if (txOffer) begin
               f = txOfferFifo;
               if (fault[0]) pulse(4'h2);
               if (fault[1]) pulse(4'h1);
               pulse(4'h8);
               {txDone, txAborted, txArbLost, txBusErr} <= 4'h0;
               // offer drops two edges after done
               repeat (3) @(posedge core_clk);
            end
         end
      end
   end
endmodule : cffc_can_node
`default_nettype wire

// *** verification/cffc_top_tb.sv ***
// Purpose: self-checking bench of the filter and FIFO control block
// Assumes: zero-wait APB, engine model in cffc_can_node
// Notes: expected results queued by drivers, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module cffc_top_tb;
   logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, abortReq, txQueueEmpty;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, irq, txOffer, txDone, txAborted, txArbLost, txBusErr, rxStore, lastErr;
   logic [4:0] txOfferFifo, txEvFifo, rxStoreFifo;
   logic rxValid = 1'b0, rxRemote = 1'b0;
   logic [10:0] rxId = 11'h000;
   logic [5:0] lat = 6'd2;
   logic [1:0] fault = 2'b00;
   logic [31:0] qBusy = 32'h0;
   logic [63:0] rdq[$], e;
   logic [4:0] rxq[$], txq[$];
   int err_total = 0, n_compared = 0, cyc = 0;
   always #25 core_clk = ~core_clk;
   cffc_top dut (.core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .txOffer(txOffer), .txOfferFifo(txOfferFifo), .abortReq(abortReq), .txDone(txDone),
      .txAborted(txAborted), .txArbLost(txArbLost), .txBusErr(txBusErr), .txEvFifo(txEvFifo),
      .txQueueEmpty(txQueueEmpty), .rxValid(rxValid), .rxId(rxId), .rxRemote(rxRemote),
      .rxStore(rxStore), .rxStoreFifo(rxStoreFifo));
   cffc_can_node node (.core_clk(core_clk), .reset(reset), .lat(lat), .fault(fault), .txOffer(txOffer),
      .txOfferFifo(txOfferFifo), .abortReq(abortReq), .txDone(txDone), .txAborted(txAborted),
      .txArbLost(txArbLost), .txBusErr(txBusErr), .txEvFifo(txEvFifo), .txQueueEmpty(txQueueEmpty),
      .qBusy(qBusy));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next setup never double-drives psel
      @(posedge core_clk);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      xfer(a, 1'b1, d, s);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
      rdq.push_back({m, v});
      xfer(a, 1'b0, 32'h0, 4'h0);
   endtask : rd
   task automatic rx(input logic [10:0] id, input logic rem);
      rxValid <= 1'b1;
      rxId <= id;
      rxRemote <= rem;
      @(posedge core_clk);
      rxValid <= 1'b0;
      @(posedge core_clk);
   endtask : rx
   task automatic settle(input string nm);
      for (int i = 0; i < 200 && (txq.size() + rxq.size()) != 0; i++) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
      chk(txq.size() + rxq.size() == 0, "missing result");
      $display("test %s done", nm);
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      if (psel && penable && pready && !pwrite) begin
         e = rdq.pop_front();
         chk((prdata & e[63:32]) === e[31:0], "read data");
      end
      if (rxStore === 1'b1) chk(rxq.size() != 0 && rxStoreFifo === rxq.pop_front(), "store fifo");
      if (txDone === 1'b1) chk(txq.size() != 0 && txOfferFifo === txq.pop_front(), "offer fifo");
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         chk(1'b0, "timeout");
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      lat = 6'($urandom(32'h01861e60) % 4 + 2);
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rd(8'h00, 32'h00800000, 32'h00e00000);
      rd(8'h8c, 32'h0, 32'hff);
      settle("reset");
      wr(8'h04, 32'h7fc5, 4'h3);
      wr(8'h04, 32'h00a0, 4'h1);
      rd(8'h04, 32'h7fc5, 32'hffff);
      wr(8'h08, 32'h2289, 4'h3);
      rd(8'h08, 32'h2289, 32'hffff);
      wr(8'h18, 32'h7f0, 4'hf);
      wr(8'h20, 32'h120, 4'hf);
      wr(8'h10, 32'h7ff, 4'hf);
      wr(8'h28, 32'h055, 4'hf);
      rxq.push_back(5'd5);
      rx(11'h12a, 1'b0);
      rx(11'h220, 1'b0);
      rxq.push_back(5'd9);
      rx(11'h055, 1'b0);
      rxq.push_back(5'd5);
      rx(11'h120 | 11'($urandom % 16), 1'b0);
      wr(8'h04, 32'h05, 4'h1);
      rx(11'h12a, 1'b0);
      settle("filter");
      wr(8'h8c, 32'h81, 4'h1);
      wr(8'h90, 32'h83, 4'h1);
      wr(8'ha4, 32'h84, 4'h1);
      lat <= 6'd6;
      txq.push_back(5'd4);
      txq.push_back(5'd3);
      wr(8'h8c, 32'h89, 4'h1);
      wr(8'h90, 32'h8b, 4'h1);
      settle("priority");
      rd(8'h8c, 32'h81, 32'hff);
      rd(8'h90, 32'h83, 32'hff);
      lat <= 6'd30;
      wr(8'h8c, 32'h89, 4'h1);
      wr(8'h8c, 32'h81, 4'h1);
      chk(abortReq[3] === 1'b1, "abort pending");
      repeat (40) @(posedge core_clk);
      rd(8'h8c, 32'hc1, 32'hff);
      wr(8'h8c, 32'h4000, 4'h2);
      rd(8'h8c, 32'h81, 32'hff);
      settle("abort");
      lat <= 6'($urandom % 4 + 2);
      fault <= 2'b11;
      txq.push_back(5'd3);
      wr(8'h8c, 32'h89, 4'h1);
      settle("fault");
      rd(8'h8c, 32'hb1, 32'hff);
      rd(8'h8c, 32'h81, 32'hff);
      fault <= 2'b00;
      qBusy <= 32'h8;
      txq.push_back(5'd3);
      txq.push_back(5'd3);
      wr(8'h8c, 32'h89, 4'h1);
      for (int i = 0; i < 200 && txq.size() > 1; i++) @(posedge core_clk);
      qBusy <= 32'h0;
      settle("queue");
      wr(8'h98, 32'h08, 4'h1);
      rd(8'h98, 32'h0, 32'hff);
      rxq.push_back(5'd9);
      txq.push_back(5'd9);
      rx(11'h055, 1'b1);
      settle("remote");
      rd(8'ha4, 32'h84, 32'hff);
      chk(irq === 1'b0, "irq masked");
      rd(8'h30, 32'h3f, 32'h3f);
      wr(8'h34, 32'h1, 4'hf);
      txq.push_back(5'd3);
      wr(8'h8c, 32'h89, 4'h1);
      settle("irq");
      chk(irq === 1'b1, "irq raised");
      rd(8'h30, 32'h1, 32'h3f);
      repeat (2) @(posedge core_clk);
      chk(irq === 1'b0, "irq cleared");
      wr(8'h00, 32'h0, 4'h4);
      wr(8'h9c, 32'h80, 4'h1);
      rd(8'h9c, 32'h0, 32'h80);
      rd(8'h40, 32'h0, 32'hffffffff);
      chk(lastErr === 1'b1, "unmapped");
      settle("mode");
      test_done();
   end
endmodule : cffc_top_tb
`default_nettype wire
